// ==== hdl/cbsp_fifo.sv ====
`timescale 1ns/10ps
module cbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  cbsp_strm_if.snk   s_in,
  cbsp_strm_if.src   s_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;
  assign s_in.ready  = cnt_reg != (AW+1)'(DEPTH);
  assign s_out.valid = cnt_reg != '0;
  assign s_out.data  = mem_reg[rd_reg];
  assign push = s_in.valid && s_in.ready;
  assign pop  = s_out.valid && s_out.ready;
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_reg] <= s_in.data;
    end
  end
endmodule

// ==== hdl/cbsp_top.sv ====
`timescale 1ns/10ps
`include "cbsp_map.svh"
module cbsp_top import cbsp_pkg::*; #(
  parameter int BIT_CYC       = `CBSP_BIT_CYC,
  parameter int REPLY_CYC     = `CBSP_REPLY_CYC,
  parameter int GAP_CYC       = `CBSP_T2_MIN_CYC,
  parameter int REPLY_MAX_CYC = `CBSP_T1_MAX_CYC,
  parameter int QUEUE_DEPTH   = 16
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_rxd,
  input  wire logic        i_jumper_dispenser,
  input  wire cbsp_items_t i_status_data,
  output logic             o_txd,
  output logic             o_dispenser_mode,
  output logic             o_clear_stb,
  output logic             o_hopper_act_stb,
  output logic             o_dispenser_act_stb,
  output logic             o_selector_act_stb,
  output logic [7:0]       o_act_code,
  output logic [31:0]      o_act_data
);
  function automatic logic [7:0] item_code(input logic [2:0] i);
    case (i)
      3'h0:    return `CBSP_DC_DISPENSED;
      3'h1:    return `CBSP_DC_ERROR;
      3'h2:    return `CBSP_DC_SENSOR;
      3'h3:    return `CBSP_DC_OPSTAT;
      3'h4:    return `CBSP_DC_COINS;
      default: return `CBSP_DC_SELSTAT;
    endcase
  endfunction
  function automatic logic [7:0] item_len(input logic [2:0] i);
    return (i == 3'h3 || i == 3'h5) ? `CBSP_LEN_BYTE : `CBSP_LEN_WORD;
  endfunction
  function automatic logic [2:0] first_bit(input logic [5:0] m);
    logic [2:0] f;
    f = 3'h0;
    for (int k = 5; k >= 0; k--) begin
      if (m[k]) f = 3'(k);
    end
    return f;
  endfunction
  function automatic logic [5:0] group_mask(input logic [4:0] dev);
    if (dev == `CBSP_DEV_HOP) return `CBSP_HOP_ITEMS;
    if (dev == `CBSP_DEV_SEL) return `CBSP_SEL_ITEMS;
    return 6'h00;
  endfunction
  function automatic logic [7:0] ack_code(input logic [5:0] m, input logic all);
    if (all || $countones(m) > 1) return `CBSP_ACK_MULTI;
    if (m != 6'h00) return `CBSP_ACK_SINGLE;
    return `CBSP_ACK_PLAIN;
  endfunction

  cbsp_strm_if #(.WIDTH(8)) q_in ();
  cbsp_strm_if #(.WIDTH(8)) q_out ();
  cbsp_fifo #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_txq (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .s_in      (q_in),
    .s_out     (q_out)
  );

  // receiver, 8n1
  logic        rx_s1_reg, rx_s2_reg, jmp_s1_reg, jmp_s2_reg;
  logic        rx_busy_reg, rx_busy_next, rx_vld_reg, rx_vld_next;
  logic [11:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0]  rx_bit_reg, rx_bit_next;
  logic [7:0]  rx_sh_reg, rx_sh_next;
  always_comb begin
    rx_busy_next = rx_busy_reg;
    rx_cnt_next  = rx_cnt_reg;
    rx_bit_next  = rx_bit_reg;
    rx_sh_next   = rx_sh_reg;
    rx_vld_next  = 1'b0;
    if (!rx_busy_reg) begin
      if (!rx_s2_reg) begin
        rx_busy_next = 1'b1;
        rx_cnt_next  = 12'(BIT_CYC / 2 - 1);
        rx_bit_next  = 4'h0;
      end
    end else if (rx_cnt_reg != 12'h000) begin
      rx_cnt_next = rx_cnt_reg - 1'b1;
    end else begin
      rx_cnt_next = 12'(BIT_CYC - 1);
      rx_bit_next = rx_bit_reg + 1'b1;
      if (rx_bit_reg == 4'h0) begin
        rx_busy_next = !rx_s2_reg;
      end else if (rx_bit_reg == `CBSP_STOP_BIT) begin
        rx_busy_next = 1'b0;
        rx_vld_next  = rx_s2_reg;
      end else begin
        rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]};
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      jmp_s1_reg  <= 1'b0;
      jmp_s2_reg  <= 1'b0;
      rx_busy_reg <= 1'b0;
      rx_vld_reg  <= 1'b0;
      rx_cnt_reg  <= '0;
      rx_bit_reg  <= '0;
      rx_sh_reg   <= '0;
    end else begin
      rx_s1_reg   <= i_rxd;
      rx_s2_reg   <= rx_s1_reg;
      jmp_s1_reg  <= i_jumper_dispenser;
      jmp_s2_reg  <= jmp_s1_reg;
      rx_busy_reg <= rx_busy_next;
      rx_vld_reg  <= rx_vld_next;
      rx_cnt_reg  <= rx_cnt_next;
      rx_bit_reg  <= rx_bit_next;
      rx_sh_reg   <= rx_sh_next;
    end
  end

  // transmitter drains the queue; busy stalls it
  logic        tx_busy_reg, tx_busy_next, tx_line_reg, tx_line_next;
  logic [11:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0]  tx_bit_reg, tx_bit_next;
  logic [8:0]  tx_sh_reg, tx_sh_next;
  assign q_out.ready = !tx_busy_reg;
  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_line_next = tx_line_reg;
    tx_cnt_next  = tx_cnt_reg;
    tx_bit_next  = tx_bit_reg;
    tx_sh_next   = tx_sh_reg;
    if (!tx_busy_reg) begin
      if (q_out.valid) begin
        tx_busy_next = 1'b1;
        tx_line_next = 1'b0;
        tx_sh_next   = {1'b1, q_out.data};
        tx_cnt_next  = 12'(BIT_CYC - 1);
        tx_bit_next  = 4'h0;
      end
    end else if (tx_cnt_reg != 12'h000) begin
      tx_cnt_next = tx_cnt_reg - 1'b1;
    end else if (tx_bit_reg == `CBSP_STOP_BIT) begin
      tx_busy_next = 1'b0;
    end else begin
      tx_line_next = tx_sh_reg[0];
      tx_sh_next   = {1'b1, tx_sh_reg[8:1]};
      tx_bit_next  = tx_bit_reg + 1'b1;
      tx_cnt_next  = 12'(BIT_CYC - 1);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_busy_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      tx_cnt_reg  <= '0;
      tx_bit_reg  <= '0;
      tx_sh_reg   <= '1;
    end else begin
      tx_busy_reg <= tx_busy_next;
      tx_line_reg <= tx_line_next;
      tx_cnt_reg  <= tx_cnt_next;
      tx_bit_reg  <= tx_bit_next;
      tx_sh_reg   <= tx_sh_next;
    end
  end

  // command and response engine
  cbsp_state_t st_reg, st_next;
  cbsp_items_t snap_reg, snap_next;
  logic [7:0]  cmd_reg, cmd_next, resp_reg, resp_next, fcc_reg, fcc_next;
  logic [7:0]  left_reg, left_next, code_reg, code_next, q_byte;
  logic [31:0] pay_reg, pay_next, word_reg, word_next;
  logic [15:0] wait_reg, wait_next;
  logic [5:0]  mask_reg, mask_next, grp, chg;
  logic [2:0]  item_reg, item_next;
  logic [1:0]  idx_reg, idx_next;
  logic        exp_reg, exp_next, err_reg, err_next;
  logic        clr_reg, clr_next, hop_reg, hop_next;
  logic        disp_reg, disp_next, sel_reg, sel_next;
  assign q_in.valid = st_reg inside {T_ACK, T_BC, T_DC, T_PAY, T_FCC};
  assign q_in.data  = q_byte;
  assign grp = group_mask(cmd_reg[7:3]);
  always_comb begin
    for (int k = 0; k < 6; k++) chg[k] = i_status_data[k] != snap_reg[k];
    unique case (st_reg)
      T_ACK:   q_byte = resp_reg;
      T_BC:    q_byte = item_len(first_bit(mask_reg));
      T_DC:    q_byte = item_code(item_reg);
      T_PAY:   q_byte = word_reg[{idx_reg, 3'b000} +: 8];
      default: q_byte = fcc_reg;
    endcase
  end
  always_comb begin
    st_next = st_reg; snap_next = snap_reg; cmd_next = cmd_reg;
    resp_next = resp_reg; fcc_next = fcc_reg; left_next = left_reg;
    code_next = code_reg; pay_next = pay_reg; word_next = word_reg;
    mask_next = mask_reg; item_next = item_reg; idx_next = idx_reg;
    exp_next = exp_reg; err_next = err_reg; wait_next = wait_reg + 1'b1;
    clr_next = 1'b0; hop_next = 1'b0; disp_next = 1'b0; sel_next = 1'b0;
    unique case (st_reg)
      R_CMD: if (rx_vld_reg) begin
        cmd_next = rx_sh_reg;
        st_next  = R_INV;
      end
      R_INV: if (rx_vld_reg) begin
        st_next = T_WAIT;
        mask_next = 6'h00;
        exp_next = 1'b0;
        resp_next = `CBSP_NAK;
        if (rx_sh_reg == ~cmd_reg && grp != 6'h00) begin
          case (cmd_reg[2:0])
            `CBSP_NUM_RESET: if (cmd_reg[7:3] == `CBSP_DEV_HOP) begin
              resp_next = `CBSP_ACK_PLAIN;
              clr_next  = 1'b1;
              snap_next = '0;
            end
            `CBSP_NUM_ALL: begin
              mask_next = grp;
              resp_next = ack_code(grp, 1'b1);
            end
            `CBSP_NUM_CHG: begin
              mask_next = grp & chg;
              resp_next = ack_code(grp & chg, 1'b0);
            end
            `CBSP_NUM_OUT: begin
              resp_next = `CBSP_ACK_PLAIN;
              exp_next  = 1'b1;
            end
            default: resp_next = `CBSP_NAK;
          endcase
        end
      end
      R_BC: if (rx_vld_reg) begin
        left_next = rx_sh_reg;
        fcc_next  = rx_sh_reg;
        err_next  = rx_sh_reg == 8'h00 || rx_sh_reg > `CBSP_MAX_PAY;
        idx_next  = 2'h0;
        pay_next  = '0;
        st_next   = R_DC;
      end
      R_DC: if (rx_vld_reg) begin
        code_next = rx_sh_reg;
        fcc_next  = fcc_reg ^ rx_sh_reg;
        st_next   = (left_reg == 8'h00) ? R_FCC : R_PAY;
      end
      R_PAY: if (rx_vld_reg) begin
        fcc_next  = fcc_reg ^ rx_sh_reg;
        if (!err_reg) pay_next[{idx_reg, 3'b000} +: 8] = rx_sh_reg;
        idx_next  = idx_reg + 1'b1;
        left_next = left_reg - 1'b1;
        if (left_reg == 8'h01) st_next = R_FCC;
      end
      R_FCC: if (rx_vld_reg) begin
        exp_next = 1'b0;
        st_next  = T_WAIT;
        if (rx_sh_reg == fcc_reg && !err_reg) begin
          resp_next = `CBSP_ACK_PLAIN;
          if (cmd_reg[7:3] == `CBSP_DEV_SEL) sel_next = 1'b1;
          else if (jmp_s2_reg) disp_next = 1'b1;
          else hop_next = 1'b1;
        end else begin
          resp_next = `CBSP_NAK;
        end
      end
      T_WAIT: if (wait_reg == 16'(REPLY_CYC - 1)) st_next = T_ACK;
      T_ACK: if (q_in.ready) begin
        st_next = exp_reg ? R_BC : (mask_reg != 6'h00) ? T_BC : R_CMD;
      end
      T_BC: if (q_in.ready) begin
        item_next = first_bit(mask_reg);
        word_next = i_status_data[first_bit(mask_reg)];
        fcc_next  = q_byte;
        st_next   = T_DC;
      end
      T_DC: if (q_in.ready) begin
        fcc_next = fcc_reg ^ q_byte;
        idx_next = 2'h0;
        st_next  = T_PAY;
      end
      T_PAY: if (q_in.ready) begin
        fcc_next = fcc_reg ^ q_byte;
        idx_next = idx_reg + 1'b1;
        if (idx_reg == 2'(item_len(item_reg) - 8'h01)) st_next = T_FCC;
      end
      T_FCC: if (q_in.ready) begin
        snap_next[item_reg] = word_reg;
        mask_next[item_reg] = 1'b0;
        st_next = (mask_next != 6'h00) ? T_BC : R_CMD;
      end
    endcase
    // our own reply going out is not host idle time
    if (st_next != st_reg || rx_busy_reg || tx_busy_reg || q_out.valid) wait_next = '0;
    if (st_reg inside {R_INV, R_BC, R_DC, R_PAY, R_FCC} && !rx_vld_reg
        && wait_reg == 16'(GAP_CYC - 1)) begin
      st_next = R_CMD;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_reg <= R_CMD; snap_reg <= '0; cmd_reg <= '0; resp_reg <= '0;
      fcc_reg <= '0; left_reg <= '0; code_reg <= '0; pay_reg <= '0;
      word_reg <= '0; mask_reg <= '0; item_reg <= '0; idx_reg <= '0;
      exp_reg <= 1'b0; err_reg <= 1'b0; wait_reg <= '0; clr_reg <= 1'b0;
      hop_reg <= 1'b0; disp_reg <= 1'b0; sel_reg <= 1'b0;
    end else begin
      st_reg <= st_next; snap_reg <= snap_next; cmd_reg <= cmd_next;
      resp_reg <= resp_next; fcc_reg <= fcc_next; left_reg <= left_next;
      code_reg <= code_next; pay_reg <= pay_next; word_reg <= word_next;
      mask_reg <= mask_next; item_reg <= item_next; idx_reg <= idx_next;
      exp_reg <= exp_next; err_reg <= err_next; wait_reg <= wait_next;
      clr_reg <= clr_next; hop_reg <= hop_next; disp_reg <= disp_next;
      sel_reg <= sel_next;
    end
  end
  assign o_txd               = tx_line_reg;
  assign o_dispenser_mode    = jmp_s2_reg;
  assign o_clear_stb         = clr_reg;
  assign o_hopper_act_stb    = hop_reg;
  assign o_dispenser_act_stb = disp_reg;
  assign o_selector_act_stb  = sel_reg;
  assign o_act_code          = code_reg;
  assign o_act_data          = pay_reg;

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_good_block;
    st_reg == R_FCC && rx_vld_reg && rx_sh_reg == fcc_reg && !err_reg;
  endsequence
  sequence s_bad_pair;
    st_reg == R_INV && rx_vld_reg && rx_sh_reg != ~cmd_reg;
  endsequence
  AST_ONE_ACTOR: assert property (!(o_hopper_act_stb && o_dispenser_act_stb))
    else $error("hopper and dispenser acted together");
  AST_BAD_PAIR_NAK: assert property (s_bad_pair |=> st_reg == T_WAIT && resp_reg == `CBSP_NAK)
    else $error("bad complement not refused");
  AST_BAD_CHECK_NAK: assert property (st_reg == R_FCC && rx_vld_reg && rx_sh_reg != fcc_reg
      |=> resp_reg == `CBSP_NAK)
    else $error("bad check byte not refused");
  AST_GOOD_ACTS: assert property (s_good_block |=> (o_hopper_act_stb || o_dispenser_act_stb
      || o_selector_act_stb) && resp_reg == `CBSP_ACK_PLAIN)
    else $error("accepted block produced no action");
  AST_REPLY_WINDOW: assert property (st_reg == T_WAIT && st_next == T_ACK
      |-> wait_reg == 16'(REPLY_CYC - 1) && wait_reg < 16'(REPLY_MAX_CYC))
    else $error("reply outside window");
  AST_PLAIN_ONLY: assert property (st_reg == T_ACK && q_in.ready && mask_reg == 6'h00 && !exp_reg
      |=> st_reg == R_CMD)
    else $error("data followed an empty answer");
  AST_SINGLE_ONE: assert property (st_reg == T_ACK && resp_reg == `CBSP_ACK_SINGLE
      |-> $countones(mask_reg) == 1)
    else $error("single code with wrong item count");
  AST_MULTI_MANY: assert property (st_reg == T_ACK && resp_reg == `CBSP_ACK_MULTI
      |-> $countones(mask_reg) > 1)
    else $error("multi code with too few items");
  AST_BLOCK_ORDER: assert property (st_reg == T_BC && q_in.ready
      |=> st_reg == T_DC ##1 st_reg inside {T_DC, T_PAY})
    else $error("block bytes out of order");
endmodule

// ==== include/cbsp_map.svh ====
`ifndef CBSP_MAP_SVH
`define CBSP_MAP_SVH
`define CBSP_CLK_MHZ 25
`define CBSP_BAUD 9600
`define CBSP_BIT_CYC (`CBSP_CLK_MHZ * 1000000 / `CBSP_BAUD)
`define CBSP_BIT_LAST 12'(`CBSP_BIT_CYC - 1)
`define CBSP_HALF_BIT 12'(`CBSP_BIT_CYC / 2 - 1)
`define CBSP_STOP_BIT 4'h9
`define CBSP_T1_MIN_NS 100000
`define CBSP_T1_MAX_NS 2000000
`define CBSP_T2_MIN_NS 600000
`define CBSP_T1_MIN_CYC ((`CBSP_T1_MIN_NS * `CBSP_CLK_MHZ + 999) / 1000)
`define CBSP_T1_MAX_CYC (`CBSP_T1_MAX_NS * `CBSP_CLK_MHZ / 1000)
`define CBSP_T2_MIN_CYC ((`CBSP_T2_MIN_NS * `CBSP_CLK_MHZ + 999) / 1000)
`define CBSP_REPLY_CYC (`CBSP_T1_MIN_CYC + `CBSP_BIT_CYC / 2)
`define CBSP_ACK_PLAIN 8'h11
`define CBSP_ACK_SINGLE 8'h22
`define CBSP_ACK_MULTI 8'h33
`define CBSP_NAK 8'hee
`define CBSP_DEV_HOP 5'h0e
`define CBSP_DEV_SEL 5'h0c
`define CBSP_NUM_RESET 3'h0
`define CBSP_NUM_ALL 3'h1
`define CBSP_NUM_CHG 3'h2
`define CBSP_NUM_OUT 3'h3
`define CBSP_HOP_ITEMS 6'h0f
`define CBSP_SEL_ITEMS 6'h30
`define CBSP_MAX_PAY 8'h04
`define CBSP_LEN_WORD 8'h04
`define CBSP_LEN_BYTE 8'h01
`define CBSP_DC_DISPENSED 8'h15
`define CBSP_DC_ERROR 8'h16
`define CBSP_DC_SENSOR 8'h17
`define CBSP_DC_OPSTAT 8'h18
`define CBSP_DC_COINS 8'h08
`define CBSP_DC_SELSTAT 8'h0b
`endif

// ==== include/cbsp_pkg.sv ====
package cbsp_pkg;
  typedef logic [5:0][31:0] cbsp_items_t;
  typedef enum logic [3:0] {
    R_CMD, R_INV, R_BC, R_DC, R_PAY, R_FCC,
    T_WAIT, T_ACK, T_BC, T_DC, T_PAY, T_FCC
  } cbsp_state_t;
endpackage

// ==== include/cbsp_strm_if.sv ====
`timescale 1ns/10ps
interface cbsp_strm_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ==== test/cbsp_host_model.sv ====
`timescale 1ns/10ps
module cbsp_host_model #(
  parameter int BIT_CYC = 2604
) (
  input  wire logic i_clk_sys,
  input  wire logic i_line_in,
  output logic      o_line_out
);
  initial o_line_out = 1'b1;

  // one 8n1 frame, lsb first, line driven just after the edge
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk_sys);
      o_line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge i_clk_sys);
    end
  endtask

  // waits bounded for a start bit, samples each bit mid-cell
  task automatic recv_byte(output logic [7:0] b, output int w);
    b = 8'hxx;
    w = 0;
    while (i_line_in !== 1'b0 && w < 60000) begin
      @(posedge i_clk_sys);
      w++;
    end
    if (w < 60000) begin
      repeat (BIT_CYC / 2) @(posedge i_clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge i_clk_sys);
        b[i] = i_line_in;
      end
      repeat (BIT_CYC) @(posedge i_clk_sys);
    end
  endtask
endmodule

// ==== test/cbsp_top_tb.sv ====
`timescale 1ns/10ps
module cbsp_top_tb;
  import cbsp_pkg::*;
  // scaled link timing keeps the run short; the gap and reply times keep the real ratios, the bit time is scaled further
  localparam int BIT   = 64;
  localparam int GAP   = 768;
  localparam int REPLY = 160;
  localparam int RMAX  = 2560;
  logic        i_clk_sys = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_jumper_dispenser = 1'b0;
  cbsp_items_t i_status_data = '0;
  wire logic   rxd;
  wire logic   txd;
  logic        o_dispenser_mode;
  logic        o_clear_stb;
  logic        o_hopper_act_stb;
  logic        o_dispenser_act_stb;
  logic        o_selector_act_stb;
  logic [7:0]  o_act_code;
  logic [31:0] o_act_data;
  int          errors = 0;
  int          cmp_count = 0;
  int          n_clr = 0;
  int          n_hop = 0;
  int          n_disp = 0;
  int          n_sel = 0;
  int          n_both = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  cbsp_top #(
    .BIT_CYC       (BIT),
    .REPLY_CYC     (REPLY),
    .GAP_CYC       (GAP),
    .REPLY_MAX_CYC (RMAX),
    .QUEUE_DEPTH   (16)
  ) dut (
    .i_clk_sys           (i_clk_sys),
    .i_rst               (i_rst),
    .i_rxd               (rxd),
    .i_jumper_dispenser  (i_jumper_dispenser),
    .i_status_data       (i_status_data),
    .o_txd               (txd),
    .o_dispenser_mode    (o_dispenser_mode),
    .o_clear_stb         (o_clear_stb),
    .o_hopper_act_stb    (o_hopper_act_stb),
    .o_dispenser_act_stb (o_dispenser_act_stb),
    .o_selector_act_stb  (o_selector_act_stb),
    .o_act_code          (o_act_code),
    .o_act_data          (o_act_data)
  );

  cbsp_host_model #(
    .BIT_CYC (BIT)
  ) host (
    .i_clk_sys  (i_clk_sys),
    .i_line_in  (txd),
    .o_line_out (rxd)
  );

  always @(posedge i_clk_sys) begin
    if (o_clear_stb === 1'b1) n_clr++;
    if (o_hopper_act_stb === 1'b1) n_hop++;
    if (o_dispenser_act_stb === 1'b1) n_disp++;
    if (o_selector_act_stb === 1'b1) n_sel++;
    if (o_hopper_act_stb === 1'b1 && o_dispenser_act_stb === 1'b1) n_both++;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rx(input logic [7:0] exp, input bit first);
    logic [7:0] b;
    int         w;
    host.recv_byte(b, w);
    chk({24'h0, b}, {24'h0, exp});
    if (first) chk(32'(w >= REPLY - BIT && w <= RMAX), 32'h1);
  endtask

  // idle gap, then command byte and its complement
  task automatic cmd(input logic [7:0] c);
    repeat (GAP) @(posedge i_clk_sys);
    host.send_byte(c);
    host.send_byte(~c);
  endtask

  task automatic blk_rx(input logic [7:0] bc, input logic [7:0] dc, input logic [31:0] d);
    logic [7:0] x;
    x = bc ^ dc;
    rx(bc, 1'b0);
    rx(dc, 1'b0);
    for (int i = 0; i < bc; i++) begin
      rx(d[8*i+:8], 1'b0);
      x ^= d[8*i+:8];
    end
    rx(x, 1'b0);
  endtask

  task automatic blk_tx(input logic [7:0] bc, input logic [7:0] dc, input logic [31:0] d,
                        input logic [7:0] flip);
    logic [7:0] x;
    x = bc ^ dc;
    host.send_byte(bc);
    host.send_byte(dc);
    for (int i = 0; i < bc; i++) begin
      host.send_byte(d[8*i+:8]);
      x ^= d[8*i+:8];
    end
    host.send_byte(x ^ flip);
  endtask

  initial begin
    repeat (90000) @(posedge i_clk_sys);
    errors++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    i_status_data[4] <= 32'h04030201;
    i_status_data[5] <= 32'h0000005a;
    cmd(8'h72);
    rx(8'h11, 1'b1);
    chk(32'(n_clr), 32'h0);
    repeat (GAP) @(posedge i_clk_sys);
    host.send_byte(8'h72);
    host.send_byte(8'h00);
    rx(8'hee, 1'b1);
    cmd(8'h60);
    rx(8'hee, 1'b1);
    cmd(8'h70);
    rx(8'h11, 1'b1);
    chk(32'(n_clr), 32'h1);
    cmd(8'h62);
    rx(8'h33, 1'b1);
    blk_rx(8'h04, 8'h08, 32'h04030201);
    blk_rx(8'h01, 8'h0b, 32'h0000005a);
    cmd(8'h62);
    rx(8'h11, 1'b1);
    @(posedge i_clk_sys);
    i_status_data[5] <= 32'h000000a6;
    cmd(8'h62);
    rx(8'h22, 1'b1);
    blk_rx(8'h01, 8'h0b, 32'h000000a6);
    cmd(8'h61);
    rx(8'h33, 1'b1);
    blk_rx(8'h04, 8'h08, 32'h04030201);
    blk_rx(8'h01, 8'h0b, 32'h000000a6);
    cmd(8'h63);
    rx(8'h11, 1'b1);
    blk_tx(8'h01, 8'h00, 32'h000000a5, 8'h00);
    rx(8'h11, 1'b1);
    chk(32'(n_sel), 32'h1);
    chk({24'h0, o_act_code}, 32'h0);
    chk(o_act_data, 32'h000000a5);
    cmd(8'h73);
    rx(8'h11, 1'b1);
    blk_tx(8'h04, 8'h00, 32'h00000500, 8'h00);
    rx(8'h11, 1'b1);
    chk(32'(n_hop), 32'h1);
    chk(o_act_data, 32'h00000500);
    cmd(8'h73);
    rx(8'h11, 1'b1);
    blk_tx(8'h01, 8'h00, 32'h00000007, 8'h40);
    rx(8'hee, 1'b1);
    chk(32'(n_hop), 32'h1);
    chk({31'h0, o_dispenser_mode}, 32'h0);
    @(posedge i_clk_sys);
    i_jumper_dispenser <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    chk({31'h0, o_dispenser_mode}, 32'h1);
    cmd(8'h73);
    rx(8'h11, 1'b1);
    blk_tx(8'h02, 8'h00, 32'h00000302, 8'h00);
    rx(8'h11, 1'b1);
    chk(32'(n_disp), 32'h1);
    chk(32'(n_hop), 32'h1);
    chk(o_act_data, 32'h00000302);
    chk(32'(n_both), 32'h0);
    summarize();
  end
endmodule
